// ---- hw/pmsh_pkg.sv ----
package pmsh_pkg;

    // ************************************************************
    // Object indices
    // ************************************************************
    localparam logic [15:0] IDX_COMMAND      = 16'h6040;
    localparam logic [15:0] IDX_STATE        = 16'h6041;
    localparam logic [15:0] IDX_QSTOP_OPTION = 16'h605a;
    localparam logic [15:0] IDX_OP_MODE      = 16'h6060;
    localparam logic [15:0] IDX_DESTINATION  = 16'h607a;
    localparam logic [15:0] IDX_VELOCITY     = 16'h6081;
    localparam logic [15:0] IDX_ACCEL        = 16'h6083;
    localparam logic [15:0] IDX_DECEL        = 16'h6084;
    localparam logic [15:0] IDX_PROFILE_TYPE = 16'h6086;

    // ************************************************************
    // Command word and state word bit positions
    // ************************************************************
    localparam int CMD_LAUNCH_BIT   = 4;
    localparam int CMD_ON_FLY_BIT   = 5;
    localparam int CMD_RELATIVE_BIT = 6;
    localparam int CMD_HALT_BIT     = 8;
    localparam int STS_ARRIVED_BIT  = 10;
    localparam int STS_ACK_BIT      = 12;

    // ************************************************************
    // Codes and reset values
    // ************************************************************
    localparam logic [15:0] PROFILE_TRAPEZOID = 16'h0000;
    localparam logic [15:0] PROFILE_SCURVE    = 16'h0003;
    localparam logic [15:0] PROFILE_VELOCITY  = 16'hffff;
    localparam logic [7:0]  MODE_PROFILE_POS  = 8'h01;
    localparam logic [15:0] QSTOP_HOLD_FIRST  = 16'h0005;
    localparam logic [15:0] QSTOP_HOLD_LAST   = 16'h0008;
    localparam logic [15:0] COMMAND_RESET     = 16'h0000;
    localparam logic [15:0] QSTOP_RESET       = 16'h0000;
    localparam logic [7:0]  OP_MODE_RESET     = 8'h00;
    localparam logic [31:0] PARAM_RESET       = 32'h0000_0000;

endpackage : pmsh_pkg

// ---- hw/pmsh_edge_detect.sv ----
`timescale 1ns/1ps

module pmsh_edge_detect
(
    ref_clk,
    sys_rst,
    level_in,
    rise_pulse
);
    input  wire logic ref_clk;
    input  wire logic sys_rst;
    input  wire logic level_in;
    output logic      rise_pulse;

    logic prev_reg;

    // Each rising edge is seen exactly once against the last cycle's sample.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            prev_reg <= 1'b0;
        else
            prev_reg <= level_in;
    end

    assign rise_pulse = level_in & ~prev_reg;

endmodule : pmsh_edge_detect

// ---- hw/pmsh_dest_calc.sv ----
`timescale 1ns/1ps

module pmsh_dest_calc
#(
    parameter int POS_W = 32
)
(
    relative_sel,
    velocity_type,
    commanded_pos,
    move_value,
    destination,
    direction_neg
);
    input  wire logic                    relative_sel;
    input  wire logic                    velocity_type;
    input  wire logic signed [POS_W-1:0] commanded_pos;
    input  wire logic signed [POS_W-1:0] move_value;
    output logic signed [POS_W-1:0]      destination;
    output logic                         direction_neg;

    // Relative adds to the commanded position and wraps like the position counter.
    always_comb
    begin
        if (velocity_type)
            destination = commanded_pos;
        else if (relative_sel)
            destination = POS_W'(commanded_pos + move_value);
        else
            destination = move_value;
    end

    // Zero counts as a positive direction.
    assign direction_neg = velocity_type & move_value[POS_W-1];

endmodule : pmsh_dest_calc

// ---- hw/pmsh_setpoint.sv ----
`timescale 1ns/1ps

// What this block does
// - Launch rising edge copies buffer to active
// - Update disabled: ignore launch while moving
// - Update enabled, trapezoid/velocity: start immediately
// - Update enabled, S-curve: keep old move
// - Reference bit: 0 absolute, 1 relative
// - Halt bit stops motion until released
// - Arrival set at target, cleared on new
// - Quick-stop codes 5..8 set arrival when halted
// - Halt also sets arrival flag
// - Acknowledge on accepted launch, cleared when low
// - Invalid launch edges leave acknowledge clear
// - Trapezoid separate decel; S-curve reuses accel
// - Destination is a signed POS_W-bit count
// - Value is distance, position, or direction
// - New destination waits for a launch
// - Moves only in profile position mode

module pmsh_setpoint
#(
    parameter int POS_W = 32
)
(
    ref_clk,
    sys_rst,
    obj_wr,
    obj_rd,
    obj_index,
    obj_wdata,
    obj_rdata,
    obj_ack,
    obj_err,
    commanded_pos,
    traj_arrived,
    qstop_done,
    move_load,
    move_destination_out,
    move_direction_neg,
    move_velocity,
    move_accel,
    move_decel,
    move_scurve,
    move_velocity_type,
    motion_halt,
    move_active
);
    input  wire logic                    ref_clk;
    input  wire logic                    sys_rst;
    input  wire logic                    obj_wr;
    input  wire logic                    obj_rd;
    input  wire logic [15:0]             obj_index;
    input  wire logic [31:0]             obj_wdata;
    output logic [31:0]                  obj_rdata;
    output logic                         obj_ack;
    output logic                         obj_err;
    input  wire logic signed [POS_W-1:0] commanded_pos;
    input  wire logic                    traj_arrived;
    input  wire logic                    qstop_done;
    output logic                         move_load;
    output logic signed [POS_W-1:0]      move_destination_out;
    output logic                         move_direction_neg;
    output logic [31:0]                  move_velocity;
    output logic [31:0]                  move_accel;
    output logic [31:0]                  move_decel;
    output logic                         move_scurve;
    output logic                         move_velocity_type;
    output logic                         motion_halt;
    output logic                         move_active;

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (POS_W < 2 || POS_W > 32)
    begin : g_bad_width
        $error("pmsh_setpoint: POS_W must lie in 2..32");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic index_known(input logic [15:0] idx);
        index_known = (idx == pmsh_pkg::IDX_COMMAND) || (idx == pmsh_pkg::IDX_STATE)
                   || (idx == pmsh_pkg::IDX_QSTOP_OPTION) || (idx == pmsh_pkg::IDX_OP_MODE)
                   || (idx == pmsh_pkg::IDX_DESTINATION) || (idx == pmsh_pkg::IDX_VELOCITY)
                   || (idx == pmsh_pkg::IDX_ACCEL) || (idx == pmsh_pkg::IDX_DECEL)
                   || (idx == pmsh_pkg::IDX_PROFILE_TYPE);
    endfunction : index_known

    function automatic logic is_scurve(input logic [15:0] code);
        is_scurve = (code == pmsh_pkg::PROFILE_SCURVE);
    endfunction : is_scurve

    // ************************************************************
    // Object store: command word, quick-stop option, mode and the next-move buffer
    // ************************************************************
    logic [15:0]             drive_command_word_reg;
    logic [15:0]             qstop_option_reg;
    logic [7:0]              op_mode_reg;
    logic signed [POS_W-1:0] move_destination_reg;
    logic [31:0]             next_velocity_reg;
    logic [31:0]             next_accel_reg;
    logic [31:0]             next_decel_reg;
    logic [15:0]             next_profile_reg;
    logic                    wr_hit;

    assign wr_hit = obj_wr & index_known(obj_index);

    // The buffer may be rewritten at any time; it only reaches the trajectory on a launch.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            drive_command_word_reg <= pmsh_pkg::COMMAND_RESET;
            qstop_option_reg       <= pmsh_pkg::QSTOP_RESET;
            op_mode_reg            <= pmsh_pkg::OP_MODE_RESET;
            move_destination_reg   <= POS_W'(pmsh_pkg::PARAM_RESET);
            next_velocity_reg      <= pmsh_pkg::PARAM_RESET;
            next_accel_reg         <= pmsh_pkg::PARAM_RESET;
            next_decel_reg         <= pmsh_pkg::PARAM_RESET;
            next_profile_reg       <= pmsh_pkg::PROFILE_TRAPEZOID;
        end
        else if (wr_hit)
        begin
            case (obj_index)
                pmsh_pkg::IDX_COMMAND:      drive_command_word_reg <= obj_wdata[15:0];
                pmsh_pkg::IDX_QSTOP_OPTION: qstop_option_reg       <= obj_wdata[15:0];
                pmsh_pkg::IDX_OP_MODE:      op_mode_reg            <= obj_wdata[7:0];
                pmsh_pkg::IDX_DESTINATION:  move_destination_reg   <= obj_wdata[POS_W-1:0];
                pmsh_pkg::IDX_VELOCITY:     next_velocity_reg      <= obj_wdata;
                pmsh_pkg::IDX_ACCEL:        next_accel_reg         <= obj_wdata;
                pmsh_pkg::IDX_DECEL:        next_decel_reg         <= obj_wdata;
                pmsh_pkg::IDX_PROFILE_TYPE: next_profile_reg       <= obj_wdata[15:0];
                default:                    next_profile_reg       <= next_profile_reg;
            endcase
        end
    end

    // ************************************************************
    // Command word decode and edge detection
    // ************************************************************
    logic launch_rise;
    logic halt_rise;
    logic pp_mode;
    logic on_fly;
    logic halt_level;

    assign pp_mode    = (op_mode_reg == pmsh_pkg::MODE_PROFILE_POS);
    assign on_fly     = drive_command_word_reg[pmsh_pkg::CMD_ON_FLY_BIT];
    assign halt_level = drive_command_word_reg[pmsh_pkg::CMD_HALT_BIT];

    pmsh_edge_detect u_launch_edge
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .level_in   (drive_command_word_reg[pmsh_pkg::CMD_LAUNCH_BIT]),
        .rise_pulse (launch_rise)
    );

    pmsh_edge_detect u_halt_edge
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .level_in   (halt_level),
        .rise_pulse (halt_rise)
    );

    // ************************************************************
    // Move state machine
    // ************************************************************
    typedef enum logic [1:0]
    {
        PMSH_IDLE   = 2'b01,
        PMSH_MOVING = 2'b10
    } pmsh_state_type;

    pmsh_state_type state_reg;
    pmsh_state_type state_next;
    logic           active_scurve_reg;
    logic           accept;

    // A running S-curve cannot be reshaped, so its edges are refused rather than queued.
    always_comb
    begin
        accept = 1'b0;
        if (launch_rise && pp_mode)
        begin
            case (state_reg)
                PMSH_IDLE:   accept = 1'b1;
                PMSH_MOVING: accept = on_fly && !active_scurve_reg;
                default:     accept = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PMSH_IDLE:
            begin
                if (accept)
                    state_next = PMSH_MOVING;
            end
            PMSH_MOVING:
            begin
                if (accept)
                    state_next = PMSH_MOVING;
                else if (traj_arrived || !pp_mode)
                    state_next = PMSH_IDLE;
            end
            default:
                state_next = PMSH_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            state_reg <= PMSH_IDLE;
        else
            state_reg <= state_next;
    end

    assign move_active = (state_reg == PMSH_MOVING);

    // ************************************************************
    // Active move registers
    // ************************************************************
    logic signed [POS_W-1:0] dest_calc;
    logic                    dir_calc;
    logic                    next_velocity_type;

    assign next_velocity_type = (next_profile_reg == pmsh_pkg::PROFILE_VELOCITY);

    pmsh_dest_calc #(.POS_W(POS_W)) u_dest
    (
        .relative_sel  (drive_command_word_reg[pmsh_pkg::CMD_RELATIVE_BIT]),
        .velocity_type (next_velocity_type),
        .commanded_pos (commanded_pos),
        .move_value    (move_destination_reg),
        .destination   (dest_calc),
        .direction_neg (dir_calc)
    );

    // Only an accepted launch moves the buffer into the active set.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            move_destination_out <= POS_W'(pmsh_pkg::PARAM_RESET);
            move_direction_neg   <= 1'b0;
            move_velocity        <= pmsh_pkg::PARAM_RESET;
            move_accel           <= pmsh_pkg::PARAM_RESET;
            move_decel           <= pmsh_pkg::PARAM_RESET;
            active_scurve_reg    <= 1'b0;
            move_velocity_type   <= 1'b0;
        end
        else if (accept)
        begin
            move_destination_out <= dest_calc;
            move_direction_neg   <= dir_calc;
            move_velocity        <= next_velocity_reg;
            move_accel           <= next_accel_reg;
            move_decel           <= is_scurve(next_profile_reg) ? next_accel_reg : next_decel_reg;
            active_scurve_reg    <= is_scurve(next_profile_reg);
            move_velocity_type   <= next_velocity_type;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            move_load <= 1'b0;
        else
            move_load <= accept;
    end

    assign move_scurve = active_scurve_reg;
    assign motion_halt = pp_mode & halt_level;

    // ************************************************************
    // State word flags
    // ************************************************************
    logic arrived_reg;
    logic ack_reg;
    logic arrive_set;
    logic qstop_hold_code;

    assign qstop_hold_code = (qstop_option_reg >= pmsh_pkg::QSTOP_HOLD_FIRST)
                          && (qstop_option_reg <= pmsh_pkg::QSTOP_HOLD_LAST);
    assign arrive_set = (move_active && traj_arrived)
                     || (qstop_done && qstop_hold_code)
                     || halt_rise;

    // Setting wins over the clear so an arrival in the launch cycle is not lost.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            arrived_reg <= 1'b0;
        else if (arrive_set)
            arrived_reg <= 1'b1;
        else if (accept)
            arrived_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ack_reg <= 1'b0;
        else if (accept)
            ack_reg <= 1'b1;
        else if (!drive_command_word_reg[pmsh_pkg::CMD_LAUNCH_BIT])
            ack_reg <= 1'b0;
    end

    logic [15:0] drive_state_word;

    always_comb
    begin
        drive_state_word = 16'h0000;
        drive_state_word[pmsh_pkg::STS_ARRIVED_BIT] = arrived_reg;
        drive_state_word[pmsh_pkg::STS_ACK_BIT]     = ack_reg;
    end

    // ************************************************************
    // Object read port
    // ************************************************************
    logic [31:0] rd_mux;

    always_comb
    begin
        case (obj_index)
            pmsh_pkg::IDX_COMMAND:      rd_mux = {16'h0000, drive_command_word_reg};
            pmsh_pkg::IDX_STATE:        rd_mux = {16'h0000, drive_state_word};
            pmsh_pkg::IDX_QSTOP_OPTION: rd_mux = {16'h0000, qstop_option_reg};
            pmsh_pkg::IDX_OP_MODE:      rd_mux = {24'h000000, op_mode_reg};
            pmsh_pkg::IDX_DESTINATION:  rd_mux = 32'(move_destination_reg);
            pmsh_pkg::IDX_VELOCITY:     rd_mux = next_velocity_reg;
            pmsh_pkg::IDX_ACCEL:        rd_mux = next_accel_reg;
            pmsh_pkg::IDX_DECEL:        rd_mux = next_decel_reg;
            pmsh_pkg::IDX_PROFILE_TYPE: rd_mux = {16'h0000, next_profile_reg};
            default:                    rd_mux = 32'h0000_0000;
        endcase
    end

    // Writes to the read-only state word are answered as errors.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            obj_rdata <= 32'h0000_0000;
            obj_ack   <= 1'b0;
            obj_err   <= 1'b0;
        end
        else
        begin
            obj_rdata <= obj_rd ? rd_mux : 32'h0000_0000;
            obj_ack   <= (obj_rd | obj_wr) & index_known(obj_index) & ~(obj_wr & (obj_index == pmsh_pkg::IDX_STATE));
            obj_err   <= (obj_rd | obj_wr) & (~index_known(obj_index) | (obj_wr & (obj_index == pmsh_pkg::IDX_STATE)));
        end
    end

endmodule : pmsh_setpoint

// ---- tb/pmsh_setpoint_properties.sv ----
`timescale 1ns/1ps

// ************************************************************
// Port checker
// ************************************************************
module pmsh_setpoint_checker
(
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        obj_wr,
    input wire logic        obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_rdata,
    input wire logic        obj_ack,
    input wire logic        obj_err,
    input wire logic        traj_arrived,
    input wire logic        move_load,
    input wire logic [31:0] move_accel,
    input wire logic [31:0] move_decel,
    input wire logic        move_scurve,
    input wire logic        move_direction_neg,
    input wire logic        move_velocity_type,
    input wire logic        motion_halt,
    input wire logic        move_active
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    answer_once_a: assert property ((obj_wr || obj_rd) |=> (obj_ack != obj_err))
        else $error("access not answered once");
    quiet_bus_a: assert property (!(obj_wr || obj_rd) |=> !obj_ack && !obj_err)
        else $error("answer without access");
    state_read_only_a: assert property (obj_wr && obj_index == pmsh_pkg::IDX_STATE |=> obj_err)
        else $error("state word write accepted");
    rdata_idle_a: assert property (!obj_ack |-> obj_rdata == 32'h0000_0000)
        else $error("read data without ack");
    load_cause_a: assert property (move_load |-> $past(obj_wr && obj_index == pmsh_pkg::IDX_COMMAND, 2))
        else $error("move load without command write");
    load_once_a: assert property (move_load |-> move_active ##1 !move_load)
        else $error("move load not a single pulse");
    scurve_decel_a: assert property (move_load && move_scurve |-> move_decel == move_accel)
        else $error("scurve decel differs from accel");
    arrive_idle_a: assert property (move_active && traj_arrived && !obj_wr && !$past(obj_wr) |=> !move_active)
        else $error("move still active after arrival");
    halt_cause_a: assert property ($rose(motion_halt) |-> $past(obj_wr))
        else $error("halt rose without a write");
    dir_velocity_a: assert property (move_direction_neg |-> move_velocity_type)
        else $error("direction outside velocity type");

    cover property (move_load);
    cover property (move_active && traj_arrived);
    cover property (obj_err);
    cover property (motion_halt);
endmodule : pmsh_setpoint_checker

bind pmsh_setpoint pmsh_setpoint_checker chk (.ref_clk, .sys_rst, .obj_wr, .obj_rd, .obj_index, .obj_rdata,
    .obj_ack, .obj_err, .traj_arrived, .move_load, .move_accel, .move_decel, .move_scurve,
    .move_direction_neg, .move_velocity_type, .motion_halt, .move_active);

// ---- tb/pmsh_master_model.sv ----
`timescale 1ns/1ps

// ************************************************************
// Network master model
// ************************************************************
module pmsh_master_model
(
    input  wire logic        ref_clk,
    input  wire logic [31:0] obj_rdata,
    input  wire logic        obj_ack,
    input  wire logic        obj_err,
    output logic             obj_wr,
    output logic             obj_rd,
    output logic [15:0]      obj_index,
    output logic [31:0]      obj_wdata
);
    initial
    begin
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 32'h0000_0000;
    end

    // Released index and data lines carry the inverse so a stale value is never mistaken for live data.
    task automatic access(input logic rd, input logic [15:0] idx, input logic [31:0] d,
                          output logic [31:0] q, output logic e, output logic hung);
        int n;
        @(negedge ref_clk);
        obj_rd = rd;
        obj_wr = !rd;
        obj_index = idx;
        obj_wdata = d;
        @(negedge ref_clk);
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        n = 0;
        while (!(obj_ack || obj_err) && n < 4)
        begin
            @(negedge ref_clk);
            n++;
        end
        q = obj_rdata;
        e = obj_err;
        hung = !(obj_ack || obj_err);
        obj_index = ~idx;
        obj_wdata = ~d;
    endtask : access

    // The launch bit is dropped first so every move starts from a fresh edge.
    task automatic launch_move(input logic [15:0] bits, output logic hung);
        logic [31:0] q;
        logic        e;
        logic        h0;
        access(1'b0, pmsh_pkg::IDX_COMMAND, {16'h0000, bits & 16'hffef}, q, e, h0);
        access(1'b0, pmsh_pkg::IDX_COMMAND, {16'h0000, bits | 16'h0010}, q, e, hung);
        hung = hung | h0;
    endtask : launch_move
endmodule : pmsh_master_model

// ---- tb/pmsh_setpoint_test.sv ----
`timescale 1ns/1ps

// ************************************************************
// Testbench
// ************************************************************
module pmsh_setpoint_test;
    logic               ref_clk, sys_rst, obj_wr, obj_rd, obj_ack, obj_err, traj_arrived, qstop_done;
    logic [15:0]        obj_index;
    logic [31:0]        obj_wdata, obj_rdata, move_velocity, move_accel, move_decel, q;
    logic signed [31:0] commanded_pos, move_destination_out;
    logic               move_load, move_direction_neg, move_scurve, move_velocity_type, motion_halt, move_active;
    logic               e, h;
    int                 err_total = 0;
    int                 n_tests = 0;

    pmsh_setpoint dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .obj_wr(obj_wr), .obj_rd(obj_rd),
        .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
        .obj_err(obj_err), .commanded_pos(commanded_pos), .traj_arrived(traj_arrived), .qstop_done(qstop_done),
        .move_load(move_load), .move_destination_out(move_destination_out), .move_direction_neg(move_direction_neg),
        .move_velocity(move_velocity), .move_accel(move_accel), .move_decel(move_decel), .move_scurve(move_scurve),
        .move_velocity_type(move_velocity_type), .motion_halt(motion_halt), .move_active(move_active));
    pmsh_master_model master (.ref_clk(ref_clk), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index), .obj_wdata(obj_wdata));

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic rd, input logic [15:0] idx, input logic [31:0] d);
        master.access(rd, idx, d, q, e, h);
        if (h)
        begin
            err_total++;
            report_and_stop;
        end
    endtask : acc

    task automatic expect_load(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (4)
        begin
            @(negedge ref_clk);
            seen = seen | move_load;
        end
        chk({31'h0, seen}, {31'h0, exp});
    endtask : expect_load

    task automatic launch(input logic [15:0] bits, input logic exp);
        master.launch_move(bits, h);
        if (h)
        begin
            err_total++;
            report_and_stop;
        end
        expect_load(exp);
    endtask : launch

    task automatic pulse(input logic qs);
        @(negedge ref_clk);
        if (qs)
            qstop_done = 1'b1;
        else
            traj_arrived = 1'b1;
        @(negedge ref_clk);
        qstop_done = 1'b0;
        traj_arrived = 1'b0;
    endtask : pulse

    task automatic s_reset;
        acc(1'b1, pmsh_pkg::IDX_COMMAND, 32'h0);
        chk(q, 32'h0);
        acc(1'b1, 16'h1234, 32'h0);
        chk({31'h0, e}, 32'h1);
        acc(1'b0, pmsh_pkg::IDX_STATE, 32'h1000);
        chk({31'h0, e}, 32'h1);
    endtask : s_reset

    task automatic s_absolute;
        acc(1'b0, pmsh_pkg::IDX_OP_MODE, 32'h1);
        acc(1'b0, pmsh_pkg::IDX_DESTINATION, 32'hffff_ff9c);
        acc(1'b0, pmsh_pkg::IDX_ACCEL, 32'h7);
        acc(1'b0, pmsh_pkg::IDX_DECEL, 32'h9);
        acc(1'b0, pmsh_pkg::IDX_VELOCITY, 32'h64);
        chk(move_destination_out, 32'h0);
        launch(16'h0000, 1'b1);
        chk(move_destination_out, 32'hffff_ff9c);
        chk({move_velocity[7:0], move_decel[11:0], move_accel[11:0]}, 32'h6400_9007);
        acc(1'b1, pmsh_pkg::IDX_STATE, 32'h0);
        chk({30'h0, q[12], q[10]}, 32'h2);
        acc(1'b0, pmsh_pkg::IDX_COMMAND, 32'h0);
        acc(1'b1, pmsh_pkg::IDX_STATE, 32'h0);
        chk({31'h0, q[12]}, 32'h0);
        pulse(1'b0);
        acc(1'b1, pmsh_pkg::IDX_STATE, 32'h0);
        chk({30'h0, q[10], move_active}, 32'h2);
    endtask : s_absolute

    task automatic s_series;
        commanded_pos = 32'sd1000;
        acc(1'b0, pmsh_pkg::IDX_DESTINATION, 32'd50);
        launch(16'h0040, 1'b1);
        chk(move_destination_out, 32'd1050);
        acc(1'b0, pmsh_pkg::IDX_DESTINATION, 32'd77);
        launch(16'h0000, 1'b0);
        acc(1'b1, pmsh_pkg::IDX_STATE, 32'h0);
        chk({31'h0, q[12]}, 32'h0);
        chk(move_destination_out, 32'd1050);
        launch(16'h0020, 1'b1);
        chk(move_destination_out, 32'd77);
        acc(1'b0, pmsh_pkg::IDX_COMMAND, 32'h0030);
        expect_load(1'b0);
        pulse(1'b0);
    endtask : s_series

    task automatic s_scurve;
        acc(1'b0, pmsh_pkg::IDX_PROFILE_TYPE, {16'h0, pmsh_pkg::PROFILE_SCURVE});
        launch(16'h0000, 1'b1);
        chk({move_scurve, move_decel[30:0]}, 32'h8000_0007);
        acc(1'b0, pmsh_pkg::IDX_DESTINATION, 32'd5);
        launch(16'h0020, 1'b0);
        acc(1'b1, pmsh_pkg::IDX_STATE, 32'h0);
        chk({31'h0, q[12]}, 32'h0);
        chk(move_destination_out, 32'd77);
        pulse(1'b0);
    endtask : s_scurve

    task automatic s_velocity;
        commanded_pos = 32'sd300;
        acc(1'b0, pmsh_pkg::IDX_PROFILE_TYPE, {16'h0, pmsh_pkg::PROFILE_VELOCITY});
        acc(1'b0, pmsh_pkg::IDX_DESTINATION, 32'hffff_ffff);
        launch(16'h0000, 1'b1);
        chk({move_velocity_type, move_direction_neg, move_destination_out[29:0]}, 32'hc000_012c);
        acc(1'b0, pmsh_pkg::IDX_DESTINATION, 32'h1);
        launch(16'h0020, 1'b1);
        chk({31'h0, move_direction_neg}, 32'h0);
        acc(1'b0, pmsh_pkg::IDX_PROFILE_TYPE, {16'h0, pmsh_pkg::PROFILE_TRAPEZOID});
        for (int c = 4; c <= 8; c++)
        begin
            acc(1'b0, pmsh_pkg::IDX_QSTOP_OPTION, c);
            launch(16'h0020, 1'b1);
            pulse(1'b1);
            acc(1'b1, pmsh_pkg::IDX_STATE, 32'h0);
            chk({31'h0, q[10]}, {31'h0, c >= 5});
        end
    endtask : s_velocity

    task automatic s_halt;
        launch(16'h0020, 1'b1);
        acc(1'b0, pmsh_pkg::IDX_COMMAND, 32'h0100);
        chk({31'h0, motion_halt}, 32'h1);
        acc(1'b1, pmsh_pkg::IDX_STATE, 32'h0);
        chk({31'h0, q[10]}, 32'h1);
        acc(1'b0, pmsh_pkg::IDX_COMMAND, 32'h0);
        chk({31'h0, motion_halt}, 32'h0);
        pulse(1'b0);
        acc(1'b0, pmsh_pkg::IDX_OP_MODE, 32'h0);
        launch(16'h0000, 1'b0);
        acc(1'b0, pmsh_pkg::IDX_COMMAND, 32'h0100);
        chk({31'h0, motion_halt}, 32'h0);
    endtask : s_halt

    initial
    begin
        traj_arrived = 1'b0;
        qstop_done = 1'b0;
        commanded_pos = 32'sd0;
        sys_rst = 1'b1;
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        s_reset;
        s_absolute;
        s_series;
        s_scurve;
        s_velocity;
        s_halt;
        report_and_stop;
    end
endmodule : pmsh_setpoint_test
